/* hdl/host_port_pkg.sv */
package host_port_pkg;

  localparam int unsigned REF_CLK_HZ = 125_000_000;
  localparam int unsigned SER_ADDR_BITS = 8;
  localparam int unsigned SER_DATA_BITS = 8;
  localparam int unsigned SER_FRAME_BITS = SER_ADDR_BITS + SER_DATA_BITS;
  // host-side serial clock half period, in reference clocks
  localparam int unsigned SCLK_HALF_CYC = 8;
  // address of the per-driver output disable register
  localparam logic [7:0] OUT_DIS_ADDR = 8'h12;
  localparam logic [7:0] OUT_DIS_RST = 8'h00;
  localparam int unsigned NUM_CHAN = 8;
  // bit 0 of the serial address byte: 1 = read
  localparam int unsigned SER_RW_BIT = 0;

  typedef enum logic [1:0] {
    MODE_HW,
    MODE_PAR,
    MODE_SER
  } op_mode_t;

  typedef enum logic [1:0] {
    JA_TX,
    JA_RX,
    JA_OFF
  } ja_pos_t;

endpackage

/* hdl/host_port_if.sv */
`timescale 1ns/10ps
interface host_port_if;
  logic       wr_pin;
  logic       rd_pin;
  logic       latch_pin;
  logic       cs_pin;
  logic       cs_pin_open;
  logic       bus_style_pin;
  logic [7:0] a_host;
  logic [7:0] d_host;
  logic       d_host_oe_n;
  logic [7:0] d_dev;
  logic       d_dev_oe_n;
  logic       serial_out;
  logic       serial_out_oe_n;

  modport device (
    input  wr_pin, rd_pin, latch_pin, cs_pin, cs_pin_open, bus_style_pin,
    input  a_host, d_host, d_host_oe_n,
    output d_dev, d_dev_oe_n, serial_out, serial_out_oe_n
  );
  modport host (
    output wr_pin, rd_pin, latch_pin, cs_pin, cs_pin_open, bus_style_pin,
    output a_host, d_host, d_host_oe_n,
    input  d_dev, d_dev_oe_n, serial_out, serial_out_oe_n
  );
endinterface

/* hdl/host_port_host.sv */
`timescale 1ns/10ps
module host_port_host
  import host_port_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_b,
  host_port_if.host       port,
  input  wire logic [1:0] i_mode,
  input  wire logic       i_bus_style,
  input  wire logic       i_muxed,
  input  wire logic       i_start,
  input  wire logic       i_read,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic [2:0] i_hw_len,
  input  wire logic [1:0] i_hw_ja,
  input  wire logic       i_hw_code,
  output logic            o_busy,
  output logic            o_done,
  output logic [7:0]      o_rdata
);

  typedef enum logic [2:0] {
    H_IDLE, H_ALE, H_SETUP, H_STROBE, H_HOLD, H_SER
  } hstate_t;

  hstate_t st_q, st_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [4:0]  bit_q, bit_d;
  logic [15:0] sh_q, sh_d;
  logic [7:0]  rd_q, rd_d;
  logic        rd_s1_q, rd_s2_q, so_s1_q, so_s2_q;
  logic        wr_q, wr_d, rdp_q, rdp_d, la_q, la_d, cs_q, cs_d;
  logic [7:0]  dh_q, dh_d;
  logic [7:0]  ah_q, ah_d;
  logic        busy_q, busy_d;
  logic        dhoe_q, dhoe_d, done_q, done_d, rdop_q, rdop_d;
  logic        par;
  logic        ms;

  assign par = (op_mode_t'(i_mode) == MODE_PAR);
  assign ms  = ~i_bus_style;

  always_comb begin
    st_d = st_q; cnt_d = cnt_q; bit_d = bit_q; sh_d = sh_q; rd_d = rd_q;
    wr_d = wr_q; rdp_d = rdp_q; la_d = la_q; cs_d = cs_q; dh_d = dh_q;
    dhoe_d = dhoe_q; done_d = 1'b0; rdop_d = rdop_q; ah_d = ah_q;
    unique case (st_q)
      H_IDLE: begin
        cs_d = 1'b1; dhoe_d = 1'b1;
        if (op_mode_t'(i_mode) == MODE_HW) begin
          wr_d = i_hw_len[0]; rdp_d = i_hw_len[1]; la_d = i_hw_len[2];
        end else if (par) begin
          // enables and data strobe idle high; only the latch idles by style
          wr_d = 1'b1; rdp_d = 1'b1; la_d = ms;
        end else begin
          la_d = 1'b0;
        end
        if (i_start && op_mode_t'(i_mode) != MODE_HW) begin
          cs_d = 1'b0; cnt_d = '0; rdop_d = i_read;
          if (par) begin
            dh_d = i_muxed ? i_addr : i_wdata;
            ah_d = i_addr;
            dhoe_d = i_muxed ? 1'b0 : i_read;
            la_d = ms ? 1'b0 : i_muxed;
            if (ms) rdp_d = i_read;
            st_d = i_muxed ? H_ALE : H_SETUP;
          end else begin
            sh_d = {i_addr[7:1], i_read, i_wdata};
            bit_d = '0;
            st_d = H_SER;
          end
        end
      end
      H_ALE: begin
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == 4'h3) begin
          la_d = ms;
          dh_d = i_wdata;
          dhoe_d = rdop_q;
          cnt_d = '0;
          st_d = H_SETUP;
        end
      end
      H_SETUP: begin
        if (ms) wr_d = 1'b0;
        else if (rdop_q) rdp_d = 1'b0;
        else wr_d = 1'b0;
        st_d = H_STROBE;
      end
      H_STROBE: begin
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == 4'hF) begin
          rd_d = rd_s2_q ? port.d_dev : rd_q;
          wr_d = 1'b1; rdp_d = 1'b1; la_d = ms;
          st_d = H_HOLD;
        end
      end
      H_HOLD: begin
        cs_d = 1'b1; dhoe_d = 1'b1; done_d = 1'b1; st_d = H_IDLE;
      end
      H_SER: begin
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == 4'(SCLK_HALF_CYC - 1)) begin
          cnt_d = '0;
          la_d = ~la_q;
          if (la_q) begin
            // sampled at the end of the high half, just before the falling edge, safe for either launch edge of the device
            if (bit_q >= 5'(SER_ADDR_BITS))
              rd_d = {so_s2_q, rd_q[7:1]};
            sh_d = {sh_q[14:0], 1'b0};
            bit_d = bit_q + 5'h1;
            if (bit_q == 5'(SER_FRAME_BITS - 1)) st_d = H_HOLD;
          end
        end
        wr_d = sh_q[15];
      end
      default: st_d = H_IDLE;
    endcase
    busy_d = (st_d != H_IDLE);
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      st_q <= H_IDLE; cnt_q <= '0; bit_q <= '0; sh_q <= '0; rd_q <= '0;
      wr_q <= 1'b1; rdp_q <= 1'b1; la_q <= 1'b0; cs_q <= 1'b1;
      dh_q <= '0; dhoe_q <= 1'b1; done_q <= 1'b0; rdop_q <= 1'b0;
      ah_q <= '0; busy_q <= 1'b0;
      rd_s1_q <= 1'b0; rd_s2_q <= 1'b0; so_s1_q <= 1'b0; so_s2_q <= 1'b0;
    end else begin
      st_q <= st_d; cnt_q <= cnt_d; bit_q <= bit_d; sh_q <= sh_d;
      rd_q <= rd_d; wr_q <= wr_d; rdp_q <= rdp_d; la_q <= la_d;
      cs_q <= cs_d; dh_q <= dh_d; dhoe_q <= dhoe_d; done_q <= done_d;
      rdop_q <= rdop_d; ah_q <= ah_d; busy_q <= busy_d;
      rd_s1_q <= ~port.d_dev_oe_n; rd_s2_q <= rd_s1_q;
      so_s1_q <= port.serial_out; so_s2_q <= so_s1_q;
    end
  end

  assign port.wr_pin        = wr_q;
  assign port.rd_pin        = rdp_q;
  assign port.latch_pin     = la_q;
  assign port.cs_pin        = (op_mode_t'(i_mode) == MODE_HW) ?
                              i_hw_ja[0] : cs_q;
  assign port.cs_pin_open   = (op_mode_t'(i_mode) == MODE_HW) &&
                              (ja_pos_t'(i_hw_ja) == JA_OFF);
  assign port.bus_style_pin = (op_mode_t'(i_mode) == MODE_HW) ?
                              i_hw_code : i_bus_style;
  assign port.d_host        = dh_q;
  assign port.a_host        = ah_q;
  assign port.d_host_oe_n   = dhoe_q;
  assign o_busy  = busy_q;
  assign o_done  = done_q;
  assign o_rdata = rd_q;

endmodule // host_port_host

/* hdl/host_port_device.sv */
`timescale 1ns/10ps
module host_port_device
  import host_port_pkg::*;
#(
  parameter int unsigned CHANNELS = NUM_CHAN
) (
  input  wire logic                i_ref_clk,
  input  wire logic                i_rst_b,
  host_port_if.device              port,
  input  wire logic [1:0]          i_mode,
  input  wire logic                i_muxed,
  input  wire logic                i_unipolar,
  input  wire logic                i_data_only,
  input  wire logic                i_tx_driver_output_enable,
  input  wire logic                i_output_edge_select,
  input  wire logic [7:0]          i_reg_rdata,
  output logic                     o_reg_wr,
  output logic                     o_reg_rd,
  output logic [7:0]               o_reg_addr,
  output logic [7:0]               o_reg_wdata,
  output logic [2:0]               o_line_length_sel,
  output logic                     o_e1_mode,
  output logic [1:0]               o_jitter_atten_position,
  output logic                     o_b8zs_hdb3_en,
  output logic                     o_ami_en,
  output logic [CHANNELS-1:0]      o_tx_hiz,
  output logic                     o_rx_sample_falling,
  output logic                     o_rx_active_low
);

  logic [2:0] wr_s_q, rd_s_q, la_s_q, cs_s_q, op_s_q, bs_s_q;
  logic [1:0] oe_s_q, ce_s_q;
  logic [7:0] a1_q, a2_q;
  logic [7:0] d1_q, d2_q;
  logic wr_p, rd_p, la_p, cs_p, op_p, bs_p, oe_p, ce_p;
  logic wr_prev_q, rd_prev_q, la_prev_q;

  // two stages into the reference domain, third stage only for edge finding
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      wr_s_q <= '1; rd_s_q <= '1; la_s_q <= '0; cs_s_q <= '1;
      op_s_q <= '0; bs_s_q <= '0; oe_s_q <= '0; ce_s_q <= '0;
      d1_q <= '0; d2_q <= '0; a1_q <= '0; a2_q <= '0;
    end else begin
      wr_s_q <= {wr_s_q[1:0], port.wr_pin};
      rd_s_q <= {rd_s_q[1:0], port.rd_pin};
      la_s_q <= {la_s_q[1:0], port.latch_pin};
      cs_s_q <= {cs_s_q[1:0], port.cs_pin};
      op_s_q <= {op_s_q[1:0], port.cs_pin_open};
      bs_s_q <= {bs_s_q[1:0], port.bus_style_pin};
      oe_s_q <= {oe_s_q[0], i_tx_driver_output_enable};
      ce_s_q <= {ce_s_q[0], i_output_edge_select};
      d1_q <= port.d_host; d2_q <= d1_q;
      a1_q <= port.a_host; a2_q <= a1_q;
    end
  end
  assign wr_p = wr_s_q[1];
  assign rd_p = rd_s_q[1];
  assign la_p = la_s_q[1];
  assign cs_p = cs_s_q[1];
  assign op_p = op_s_q[1];
  assign bs_p = bs_s_q[1];
  assign oe_p = oe_s_q[1];
  assign ce_p = ce_s_q[1];
  assign wr_prev_q = wr_s_q[2];
  assign rd_prev_q = rd_s_q[2];
  assign la_prev_q = la_s_q[2];

  op_mode_t mode;
  assign mode = op_mode_t'(i_mode);

  typedef enum logic [1:0] { D_IDLE, D_PAR, D_SER } dstate_t;

  dstate_t st_q, st_d;
  logic [7:0]  addr_q, addr_d, wd_q, wd_d, od_q, od_d;
  logic [15:0] sh_q, sh_d;
  logic [4:0]  bit_q, bit_d;
  logic [7:0]  rdsh_q, rdsh_d, dd_q, dd_d;
  logic        so_q, so_d, sooe_q, sooe_d, ddoe_q, ddoe_d;
  logic        regwr_q, regwr_d, regrd_q, regrd_d;
  logic        ms;
  logic        la_rise, la_fall, sclk_out_edge, sclk_in_edge;

  assign ms = ~bs_p;
  assign la_rise = la_p & ~la_prev_q;
  assign la_fall = ~la_p & la_prev_q;
  // serial in taken on rising clock; out edge follows edge select
  assign sclk_in_edge  = la_rise;
  assign sclk_out_edge = ce_p ? la_rise : la_fall;

  always_comb begin
    st_d = st_q; addr_d = addr_q; wd_d = wd_q; od_d = od_q; sh_d = sh_q;
    bit_d = bit_q; rdsh_d = rdsh_q; dd_d = dd_q; so_d = so_q;
    sooe_d = sooe_q; ddoe_d = ddoe_q; regwr_d = 1'b0; regrd_d = 1'b0;
    if (mode == MODE_PAR && !cs_p) begin
      // transparent while the latch is open: the closing edge and the next
      // bus value arrive together, so an edge-triggered grab would miss
      if (i_muxed && !ms && la_p) addr_d = d2_q;
      if (i_muxed && ms && !la_p) addr_d = d2_q;
      if (!i_muxed) addr_d = a2_q;
    end
    unique case (st_q)
      D_IDLE: begin
        sooe_d = 1'b1; ddoe_d = 1'b1;
        if (!cs_p && mode == MODE_PAR && !(i_muxed && (ms ? ~la_p : la_p)))
          st_d = D_PAR;
        if (!cs_p && mode == MODE_SER) begin
          bit_d = '0; st_d = D_SER;
        end
      end
      D_PAR: begin
        if (!ms && wr_prev_q && !wr_p) begin
          wd_d = d2_q; regwr_d = 1'b1;
          if (addr_q == OUT_DIS_ADDR) od_d = d2_q;
        end
        if (!ms && !rd_p) begin
          dd_d = (addr_q == OUT_DIS_ADDR) ? od_q : i_reg_rdata;
          ddoe_d = 1'b0;
          regrd_d = rd_prev_q;
        end else if (!ms) ddoe_d = 1'b1;
        if (ms && !wr_p) begin
          if (rd_p) begin
            dd_d = (addr_q == OUT_DIS_ADDR) ? od_q : i_reg_rdata;
            ddoe_d = 1'b0; regrd_d = wr_prev_q;
          end else if (wr_prev_q) begin
            wd_d = d2_q; regwr_d = 1'b1;
            if (addr_q == OUT_DIS_ADDR) od_d = d2_q;
          end
        end else if (ms) ddoe_d = 1'b1;
        if (cs_p) begin
          ddoe_d = 1'b1; st_d = D_IDLE;
        end
      end
      D_SER: begin
        if (sclk_in_edge && bit_q < 5'(SER_FRAME_BITS)) begin
          sh_d = {sh_q[14:0], wr_p};
          bit_d = bit_q + 5'h1;
          if (bit_q == 5'(SER_ADDR_BITS - 1)) begin
            addr_d = {sh_q[6:0], wr_p};
            regrd_d = wr_p;
            rdsh_d = ({sh_q[6:0], 1'b0} == OUT_DIS_ADDR) ? od_q : i_reg_rdata;
          end
          if (bit_q == 5'(SER_FRAME_BITS - 1) && !addr_q[SER_RW_BIT]) begin
            wd_d = {sh_q[6:0], wr_p}; regwr_d = 1'b1;
            if (addr_q == OUT_DIS_ADDR) od_d = {sh_q[6:0], wr_p};
          end
        end
        if (sclk_out_edge && bit_q >= 5'(SER_ADDR_BITS) &&
            bit_q < 5'(SER_FRAME_BITS) && addr_q[SER_RW_BIT]) begin
          so_d = rdsh_q[0]; sooe_d = 1'b0;
          rdsh_d = {1'b0, rdsh_q[7:1]};
        end
        if (!addr_q[SER_RW_BIT] || bit_q < 5'(SER_ADDR_BITS))
          sooe_d = 1'b1;
        if (cs_p) begin
          sooe_d = 1'b1; st_d = D_IDLE;
        end
      end
      default: st_d = D_IDLE;
    endcase
    if (mode == MODE_HW) begin
      st_d = D_IDLE; sooe_d = 1'b1; ddoe_d = 1'b1;
    end
  end

  // line length, jitter attenuator and code pins are static levels, taken only while in hardware mode
  logic [2:0] len_q, len_d;
  logic [1:0] ja_q, ja_d;
  logic       code_q, code_d;
  logic [CHANNELS-1:0] hiz_d;
  logic       fall_d, alow_d, fall_q, alow_q;

  always_comb begin
    len_d = len_q; ja_d = ja_q; code_d = code_q;
    if (mode == MODE_HW) begin
      len_d = {la_p, rd_p, wr_p};
      ja_d = op_p ? JA_OFF : (cs_p ? JA_RX : JA_TX);
      code_d = bs_p;
    end
    for (int i = 0; i < CHANNELS; i++) begin
      hiz_d[i] = ~oe_p | (mode != MODE_HW && i < 8 && od_q[i % 8]);
    end
    fall_d = ~i_data_only & ce_p;
    alow_d = i_data_only & ~ce_p;
  end

  logic [CHANNELS-1:0] hiz_q;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      st_q <= D_IDLE; addr_q <= '0; wd_q <= '0; od_q <= OUT_DIS_RST;
      sh_q <= '0; bit_q <= '0; rdsh_q <= '0; dd_q <= '0; so_q <= 1'b0;
      sooe_q <= 1'b1; ddoe_q <= 1'b1; regwr_q <= 1'b0; regrd_q <= 1'b0;
      len_q <= '0; ja_q <= JA_OFF; code_q <= 1'b0; hiz_q <= '1;
      fall_q <= 1'b0; alow_q <= 1'b0;
    end else begin
      st_q <= st_d; addr_q <= addr_d; wd_q <= wd_d; od_q <= od_d;
      sh_q <= sh_d; bit_q <= bit_d; rdsh_q <= rdsh_d; dd_q <= dd_d;
      so_q <= so_d; sooe_q <= sooe_d; ddoe_q <= ddoe_d;
      regwr_q <= regwr_d; regrd_q <= regrd_d;
      len_q <= len_d; ja_q <= ja_d; code_q <= code_d; hiz_q <= hiz_d;
      fall_q <= fall_d; alow_q <= alow_d;
    end
  end

  logic e1_q, b8_q, ami_q;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      e1_q <= 1'b0; b8_q <= 1'b0; ami_q <= 1'b0;
    end else begin
      // length codes of 000 and 001 select E1, the rest T1/J1
      e1_q  <= (len_q[2:1] == 2'b00);
      b8_q  <= (mode == MODE_HW) & i_unipolar & ~code_q;
      ami_q <= (mode == MODE_HW) & i_unipolar & code_q;
    end
  end

  assign port.d_dev           = dd_q;
  assign port.d_dev_oe_n      = ddoe_q;
  assign port.serial_out      = so_q;
  assign port.serial_out_oe_n = sooe_q;
  assign o_reg_wr             = regwr_q;
  assign o_reg_rd             = regrd_q;
  assign o_reg_addr           = addr_q;
  assign o_reg_wdata          = wd_q;
  assign o_line_length_sel    = len_q;
  assign o_e1_mode            = e1_q;
  assign o_jitter_atten_position = ja_q;
  assign o_b8zs_hdb3_en       = b8_q;
  assign o_ami_en             = ami_q;
  assign o_tx_hiz             = hiz_q;
  assign o_rx_sample_falling  = fall_q;
  assign o_rx_active_low      = alow_q;

endmodule // host_port_device

/* verif/host_port_props.sv */
`timescale 1ns/10ps
module host_port_props
  import host_port_pkg::*;
(
  input wire logic       i_ref_clk,
  input wire logic       i_rst_b,
  input wire logic [1:0] i_mode,
  input wire logic       wr_pin,
  input wire logic       rd_pin,
  input wire logic       latch_pin,
  input wire logic       cs_pin,
  input wire logic       bus_style_pin,
  input wire logic       d_host_oe_n,
  input wire logic       d_dev_oe_n,
  input wire logic       serial_out_oe_n
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  property p_hw_quiet;
    (i_mode == MODE_HW) [*4] |-> d_dev_oe_n && serial_out_oe_n;
  endproperty
  a_hw_quiet: assert property (p_hw_quiet)
    else $error("device drives a pin in hardware mode");
  // the six-cycle wait covers the pin synchronisers and output register
  property p_cs_idle;
    (cs_pin && i_mode != MODE_HW) [*6] |-> d_dev_oe_n && serial_out_oe_n;
  endproperty
  a_cs_idle: assert property (p_cs_idle)
    else $error("device drives while chip select is high");
  property p_no_clash;
    !(!d_host_oe_n && !d_dev_oe_n);
  endproperty
  a_no_clash: assert property (p_no_clash)
    else $error("host and device drive the data bus together");
  property p_dev_par;
    !d_dev_oe_n |-> i_mode == MODE_PAR;
  endproperty
  a_dev_par: assert property (p_dev_par)
    else $error("parallel data driven outside parallel mode");
  property p_ser_only;
    !serial_out_oe_n |-> i_mode == MODE_SER;
  endproperty
  a_ser_only: assert property (p_ser_only)
    else $error("serial output driven outside serial mode");
  property p_sep_rd;
    (i_mode == MODE_PAR && bus_style_pin && rd_pin) [*6] |-> d_dev_oe_n;
  endproperty
  a_sep_rd: assert property (p_sep_rd)
    else $error("read data driven without read enable");
  property p_strobe_dir;
    (i_mode == MODE_PAR && !bus_style_pin && !rd_pin) [*6] |-> d_dev_oe_n;
  endproperty
  a_strobe_dir: assert property (p_strobe_dir)
    else $error("read data driven on a write access");
  property p_strobe_ds;
    (i_mode == MODE_PAR && !bus_style_pin && wr_pin) [*6] |-> d_dev_oe_n;
  endproperty
  a_strobe_ds: assert property (p_strobe_ds)
    else $error("read data driven without data strobe");
  property p_sep_excl;
    (i_mode == MODE_PAR) [*3] ##0 bus_style_pin |-> wr_pin || rd_pin;
  endproperty
  a_sep_excl: assert property (p_sep_excl)
    else $error("read and write enables low together");
  property p_sclk_still;
    (i_mode == MODE_SER && cs_pin) [*4] |-> $stable(latch_pin);
  endproperty
  a_sclk_still: assert property (p_sclk_still)
    else $error("serial clock moves outside a frame");

  c_par_rd: cover property (!d_dev_oe_n);
  c_ser_rd: cover property (!serial_out_oe_n);
  c_ser_frame: cover property (i_mode == MODE_SER && $fell(cs_pin));
endmodule // host_port_props

/* verif/host_port_pin_mode_control_tb.sv */
`timescale 1ns/10ps
module host_port_pin_mode_control_tb;
  import host_port_pkg::*;
  logic       i_ref_clk, i_rst_b, style, muxed, start, rd, hw_code;
  logic       unip, donly, tx_driver_output_enable, edge_sel, busy, done, reg_wr, reg_rd;
  logic       e1, b8zs, ami, rx_fall, rx_low, ser_wr;
  logic [1:0] mode, hw_ja, ja_pos;
  logic [2:0] hw_len, len_sel;
  logic [7:0] addr, wdata, rdata, reg_rdata, reg_addr, reg_wdata, tx_hiz;
  logic [7:0] cap_addr, cap_data, n_wr, n_rd, so_drv;
  int         miscompares = 0;
  int         checks = 0;

  host_port_if i_host_port_if ();
  host_port_host i_host_port_host (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .port(i_host_port_if),
    .i_mode(mode), .i_bus_style(style), .i_muxed(muxed), .i_start(start),
    .i_read(rd), .i_addr(addr), .i_wdata(wdata), .i_hw_len(hw_len),
    .i_hw_ja(hw_ja), .i_hw_code(hw_code), .o_busy(busy), .o_done(done),
    .o_rdata(rdata));
  host_port_device i_host_port_device (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .port(i_host_port_if),
    .i_mode(mode), .i_muxed(muxed), .i_unipolar(unip),
    .i_data_only(donly), .i_tx_driver_output_enable(tx_driver_output_enable),
    .i_output_edge_select(edge_sel), .i_reg_rdata(reg_rdata),
    .o_reg_wr(reg_wr), .o_reg_rd(reg_rd), .o_reg_addr(reg_addr),
    .o_reg_wdata(reg_wdata), .o_line_length_sel(len_sel), .o_e1_mode(e1),
    .o_jitter_atten_position(ja_pos), .o_b8zs_hdb3_en(b8zs),
    .o_ami_en(ami), .o_tx_hiz(tx_hiz), .o_rx_sample_falling(rx_fall),
    .o_rx_active_low(rx_low));
  host_port_props i_host_port_props (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_mode(mode),
    .wr_pin(i_host_port_if.wr_pin), .rd_pin(i_host_port_if.rd_pin),
    .latch_pin(i_host_port_if.latch_pin), .cs_pin(i_host_port_if.cs_pin),
    .bus_style_pin(i_host_port_if.bus_style_pin),
    .d_host_oe_n(i_host_port_if.d_host_oe_n),
    .d_dev_oe_n(i_host_port_if.d_dev_oe_n),
    .serial_out_oe_n(i_host_port_if.serial_out_oe_n));

  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end

  // sampled mid-cycle so registered pulses are settled
  always @(negedge i_ref_clk) begin
    if (reg_wr === 1'b1) begin
      n_wr++;
      cap_addr = reg_addr;
      cap_data = reg_wdata;
    end
    if (reg_rd === 1'b1) begin
      n_rd++;
      cap_addr = reg_addr;
    end
    if (ser_wr && i_host_port_if.serial_out_oe_n !== 1'b1) begin
      so_drv++;
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic xfer(input logic r, input logic [7:0] a, input logic [7:0] d);
    int n;
    repeat (4) @(negedge i_ref_clk);
    n_wr = 8'h00;
    n_rd = 8'h00;
    rd = r;
    addr = a;
    wdata = d;
    start = 1'b1;
    @(negedge i_ref_clk);
    start = 1'b0;
    chk(busy, 8'h01);
    n = 0;
    while (done !== 1'b1 && n < 2000) begin
      @(negedge i_ref_clk);
      n++;
    end
    if (n >= 2000) begin
      miscompares++;
      end_sim();
    end
    repeat (8) @(negedge i_ref_clk);
    chk(busy, 8'h00);
  endtask

  task automatic t_hw;
    mode = MODE_HW;
    n_wr = 8'h00;
    for (int i = 0; i < 8; i++) begin
      hw_len = i[2:0];
      hw_ja = 2'(i % 3);
      hw_code = i[0];
      tx_driver_output_enable = i[1];
      donly = i[1];
      edge_sel = i[2];
      repeat (8) @(negedge i_ref_clk);
      chk(len_sel, hw_len);
      chk(e1, i < 2);
      chk(ja_pos, hw_ja);
      chk(b8zs, !hw_code);
      chk(ami, hw_code);
      chk(tx_hiz, tx_driver_output_enable ? 8'h00 : 8'hFF);
      chk(rx_low, donly && !edge_sel);
      chk(rx_fall, !donly && edge_sel);
    end
    chk(n_wr, 8'h00);
    unip = 1'b0;
    repeat (6) @(negedge i_ref_clk);
    chk(b8zs, 8'h00);
    chk(ami, 8'h00);
    unip = 1'b1;
  endtask

  task automatic t_par;
    mode = MODE_PAR;
    tx_driver_output_enable = 1'b1;
    for (int i = 0; i < 8; i++) begin
      style = i[0];
      muxed = i[1];
      reg_rdata = 8'h3C ^ i[7:0];
      xfer(i[2], 8'h40 + i[7:0], 8'hA0 + i[7:0]);
      chk(cap_addr, 8'h40 + i[7:0]);
      if (i[2]) begin
        chk(rdata, reg_rdata);
        chk(n_wr, 8'h00);
      end else begin
        chk(cap_data, 8'hA0 + i[7:0]);
        chk(n_wr, 8'h01);
      end
    end
    chk(tx_hiz, OUT_DIS_RST);
  endtask

  task automatic t_ser;
    mode = MODE_SER;
    for (int i = 0; i < 4; i++) begin
      edge_sel = i[1];
      reg_rdata = 8'h96 ^ i[7:0];
      ser_wr = !i[0];
      so_drv = 8'h00;
      xfer(i[0], 8'h54 + i[7:0], 8'h5A ^ i[7:0]);
      ser_wr = 1'b0;
      chk(cap_addr & 8'hFE, (8'h54 + i[7:0]) & 8'hFE);
      if (i[0]) begin
        chk(rdata, reg_rdata);
        chk(n_rd, 8'h01);
      end else begin
        chk(cap_data, 8'h5A ^ i[7:0]);
        chk(so_drv, 8'h00);
      end
    end
  endtask

  task automatic t_dis;
    mode = MODE_PAR;
    style = 1'b1;
    muxed = 1'b0;
    xfer(1'b0, OUT_DIS_ADDR, 8'hA5);
    chk(tx_hiz, 8'hA5);
    xfer(1'b1, OUT_DIS_ADDR, 8'h00);
    chk(rdata, 8'hA5);
    tx_driver_output_enable = 1'b0;
    repeat (6) @(negedge i_ref_clk);
    chk(tx_hiz, 8'hFF);
  endtask

  initial begin
    i_rst_b = 1'b0;
    mode = MODE_HW;
    style = 1'b1;
    muxed = 1'b0;
    start = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    hw_len = 3'h0;
    hw_ja = 2'h0;
    hw_code = 1'b0;
    unip = 1'b1;
    donly = 1'b0;
    tx_driver_output_enable = 1'b1;
    edge_sel = 1'b0;
    reg_rdata = 8'h00;
    ser_wr = 1'b0;
    repeat (10) @(negedge i_ref_clk);
    i_rst_b = 1'b1;
    repeat (4) @(negedge i_ref_clk);
    t_hw();
    t_par();
    t_ser();
    t_dis();
    end_sim();
  end
endmodule // host_port_pin_mode_control_tb
